// file: design/board_ctrl_pkg.sv
// Constants and types for the power loss, fan and watchdog controller.
// Assumes a single 25 MHz clock domain.
package board_ctrl_pkg;

	localparam int unsigned CLK_HZ          = 25000000;
	// Standby stability window, in seconds
	localparam int unsigned STANDBY_WIN_S   = 30;
	localparam int unsigned STANDBY_WIN_CYC = STANDBY_WIN_S * CLK_HZ;
	// Tach gate interval, in milliseconds
	localparam int unsigned GATE_MS         = 1000;
	localparam int unsigned GATE_CYC        = GATE_MS * (CLK_HZ / 1000);
	// Scale from revolutions per gate to revolutions per minute
	localparam int unsigned RPM_SCALE       = 60000 / GATE_MS;
	localparam int unsigned PULSES_PER_REV  = 2;
	// Watchdog stage time, in milliseconds
	localparam int unsigned WDOG_STAGE_MS   = 1000;
	localparam int unsigned WDOG_STAGE_CYC  = WDOG_STAGE_MS * (CLK_HZ / 1000);
	localparam int unsigned WDOG_STAGES     = 3;

	localparam logic [7:0]  PWM_DUTY_RESET  = 8'h80;
	localparam logic        LAST_ON_RESET   = 1'b0;

	typedef enum logic [1:0] {
		POLICY_ALWAYS_ON,
		POLICY_STAY_OFF,
		POLICY_PREVIOUS,
		POLICY_UNUSED
	} policy_type;

	// Stage actions; no action raises a non-maskable interrupt
	typedef enum logic [1:0] {
		WACT_NONE,
		WACT_EVENT,
		WACT_RESET,
		WACT_POWER_OFF
	} wdog_action_type;

endpackage : board_ctrl_pkg

// file: design/fan_tach_meter.sv
// Fan speed meter: counts tach pulses over a fixed gate and scales to RPM.
// Assumes the tach input is already synchronised to clk_sys.
`timescale 1ns/1ps
module fan_tach_meter #(
	parameter int unsigned GATE_CYC = board_ctrl_pkg::GATE_CYC
) (
	input  wire logic        clk_sys,
	input  wire logic        reset,
	input  wire logic        tach,
	output logic      [15:0] rpm
);

	logic [31:0] gate_count;
	logic [15:0] pulse_count;
	logic        tach_prev;
	logic        gate_end;
	logic        edge_seen;
	logic [15:0] pulse_total;

	assign gate_end    = (gate_count == 32'(GATE_CYC - 1));
	assign edge_seen   = tach && !tach_prev;
	// An edge in the gate's last cycle still belongs to that gate
	assign pulse_total = pulse_count + {15'h0, edge_seen};

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			tach_prev <= 1'b0;
		end else begin
			tach_prev <= tach;
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			gate_count <= 32'h0;
		end else if (gate_end) begin
			gate_count <= 32'h0;
		end else begin
			gate_count <= gate_count + 32'h1;
		end
	end

	// Halve the pulse count, then scale one gate up to a minute
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			pulse_count <= 16'h0;
			rpm         <= 16'h0;
		end else if (gate_end) begin
			pulse_count <= 16'h0;
			rpm <= 16'((32'(pulse_total) / board_ctrl_pkg::PULSES_PER_REV)
				* board_ctrl_pkg::RPM_SCALE);
		end else if (edge_seen) begin
			pulse_count <= pulse_count + 16'h1;
		end
	end

endmodule : fan_tach_meter

// file: design/board_ctrl.sv
// Power loss recovery, fan PWM and tach, and staged watchdog controller.
// Assumes standby_good comes from a rail comparator outside this clock;
// host strobes come from logic on clk_sys.
// How it works
// - Standby rail is sampled every clock after soft-off or no-power.
// - Standby stable for the whole 30 s window means a proper switch-off.
// - Standby lost before 30 s means an AC power loss.
// - Always-on policy powers the system up when standby returns.
// - Stay-off policy keeps the system off when standby returns.
// - Previous-state policy restores the remembered on or off state.
// - The 30 s window runs only under the previous-state policy.
// - Loss soon after shutdown may remember the state as on.
// - Without a standby rail the policy has no effect.
// - A PWM output sets the system fan speed.
// - Fan RPM is derived from tach pulses.
// - Staged watchdog advances unless the host kicks it.
// - No watchdog stage raises a non-maskable interrupt.
`timescale 1ns/1ps
module board_ctrl #(
	parameter int unsigned STANDBY_WIN_CYC = board_ctrl_pkg::STANDBY_WIN_CYC,
	parameter int unsigned GATE_CYC        = board_ctrl_pkg::GATE_CYC,
	parameter int unsigned WDOG_STAGE_CYC  = board_ctrl_pkg::WDOG_STAGE_CYC
) (
	input  wire logic                            clk_sys,
	input  wire logic                            reset,
	input  wire logic                            standby_good,
	input  wire logic                            standby_supported,
	input  wire board_ctrl_pkg::policy_type      policy,
	input  wire logic                            sys_on,
	input  wire logic                            fan_rotation_pulse_in,
	input  wire logic [7:0]                      fan_duty,
	input  wire logic                            wdog_enable,
	input  wire logic                            wdog_kick,
	input  wire board_ctrl_pkg::wdog_action_type wdog_stage_action [3],
	output logic                                 power_up_req,
	output logic                                 proper_off,
	output logic                                 ac_loss,
	output logic                                 last_state_on,
	output logic                                 fan_speed_pulse_out,
	output logic      [15:0]                     fan_rpm,
	output logic      [1:0]                      wdog_stage,
	output logic                                 wdog_event,
	output logic                                 wdog_reset_req,
	output logic                                 wdog_power_off_req
);

	// Synchronisers for pins from outside the clock domain
	logic [1:0] sb_sync;
	logic [1:0] tach_sync;
	logic       sb;
	logic       sb_prev;
	logic       sys_on_prev;
	logic       monitoring;
	logic [31:0] win_count;
	logic        loss_seen;

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			sb_sync   <= 2'b00;
			tach_sync <= 2'b00;
		end else begin
			sb_sync   <= {sb_sync[0], standby_good};
			tach_sync <= {tach_sync[0], fan_rotation_pulse_in};
		end
	end
	assign sb = sb_sync[1];

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			sb_prev     <= 1'b0;
			sys_on_prev <= 1'b0;
		end else begin
			sb_prev     <= sb;
			sys_on_prev <= sys_on;
		end
	end

	// State stored at every power transition; a rail loss inside the
	// window is taken as a loss while running, so it reads as on.
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			last_state_on <= board_ctrl_pkg::LAST_ON_RESET;
		end else if (sys_on != sys_on_prev) begin
			last_state_on <= sys_on;
		end else if (monitoring && !sb) begin
			last_state_on <= 1'b1;
		end
	end

	// Window arms on shutdown, only under the previous-state policy
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			monitoring <= 1'b0;
			win_count  <= 32'h0;
			proper_off <= 1'b0;
			ac_loss    <= 1'b0;
		end else if (sys_on_prev && !sys_on && standby_supported
				&& policy == board_ctrl_pkg::POLICY_PREVIOUS) begin
			monitoring <= 1'b1;
			win_count  <= 32'h0;
			proper_off <= 1'b0;
			ac_loss    <= 1'b0;
		end else if (monitoring) begin
			if (!sb) begin
				monitoring <= 1'b0;
				ac_loss    <= 1'b1;
			end else if (win_count == 32'(STANDBY_WIN_CYC - 1)) begin
				monitoring <= 1'b0;
				proper_off <= 1'b1;
			end else begin
				win_count <= win_count + 32'h1;
			end
		end else if (sys_on) begin
			proper_off <= 1'b0;
			ac_loss    <= 1'b0;
		end
	end

	// Loss remembered across standby absence, cleared once acted on
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			loss_seen <= 1'b0;
		end else if (!sb && !sys_on) begin
			loss_seen <= 1'b1;
		end else if (sb && sb_prev) begin
			loss_seen <= 1'b0;
		end
	end

	// Recovery on standby return
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			power_up_req <= 1'b0;
		end else begin
			power_up_req <= 1'b0;
			if (sb && !sb_prev && loss_seen && standby_supported) begin
				unique case (policy)
					board_ctrl_pkg::POLICY_ALWAYS_ON:
						power_up_req <= 1'b1;
					board_ctrl_pkg::POLICY_STAY_OFF:
						power_up_req <= 1'b0;
					board_ctrl_pkg::POLICY_PREVIOUS:
						power_up_req <= last_state_on;
					default:
						power_up_req <= 1'b0;
				endcase
			end
		end
	end

	// Fan PWM; 8-bit resolution trades fine steps for a fast carrier
	logic [7:0] pwm_count;
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			pwm_count           <= 8'h0;
			fan_speed_pulse_out <= 1'b0;
		end else begin
			pwm_count           <= pwm_count + 8'h1;
			fan_speed_pulse_out <= (pwm_count < fan_duty);
		end
	end

	// Tach input assumes two pulses per revolution from the fan
	fan_tach_meter #(
		.GATE_CYC (GATE_CYC)
	) u_tach (
		.clk_sys (clk_sys),
		.reset   (reset),
		.tach    (tach_sync[1]),
		.rpm     (fan_rpm)
	);

	// Watchdog: each unkicked stage period advances one stage, holding at the last stage
	logic [31:0] wd_count;
	logic        wd_expire;
	board_ctrl_pkg::wdog_action_type act;
	assign wd_expire = (wd_count == 32'(WDOG_STAGE_CYC - 1));
	assign act = wdog_stage_action[wdog_stage];

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			wd_count   <= 32'h0;
			wdog_stage <= 2'h0;
		end else if (!wdog_enable || wdog_kick) begin
			wd_count   <= 32'h0;
			wdog_stage <= 2'h0;
		end else if (wd_expire) begin
			wd_count <= 32'h0;
			if (wdog_stage != 2'(board_ctrl_pkg::WDOG_STAGES - 1)) begin
				wdog_stage <= wdog_stage + 2'h1;
			end
		end else begin
			wd_count <= wd_count + 32'h1;
		end
	end

	// Action outputs; there is no NMI output at all
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			wdog_event         <= 1'b0;
			wdog_reset_req     <= 1'b0;
			wdog_power_off_req <= 1'b0;
		end else begin
			wdog_event <= wdog_enable && !wdog_kick && wd_expire
				&& act == board_ctrl_pkg::WACT_EVENT;
			wdog_reset_req <= wdog_enable && !wdog_kick && wd_expire
				&& act == board_ctrl_pkg::WACT_RESET;
			wdog_power_off_req <= wdog_enable && !wdog_kick && wd_expire
				&& act == board_ctrl_pkg::WACT_POWER_OFF;
		end
	end

	sequence s_shutdown_prev;
		$fell(sys_on) && standby_supported
			&& policy == board_ctrl_pkg::POLICY_PREVIOUS;
	endsequence

	a_loss_flag_set: assert property (@(posedge clk_sys) disable iff (reset)
		monitoring && !sb |=> ac_loss && !monitoring)
		else $error("standby loss in window not flagged");
	a_window_only_prev: assert property (@(posedge clk_sys)
		disable iff (reset)
		$fell(sys_on) && policy != board_ctrl_pkg::POLICY_PREVIOUS
		&& !monitoring |=> !monitoring)
		else $error("window armed outside previous-state policy");
	a_window_arms: assert property (@(posedge clk_sys) disable iff (reset)
		s_shutdown_prev |-> ##1 monitoring)
		else $error("window not armed at shutdown");
	a_no_rail_no_up: assert property (@(posedge clk_sys) disable iff (reset)
		!$past(standby_supported) |-> !power_up_req)
		else $error("recovery acted without standby rail");
	a_stayoff_quiet: assert property (@(posedge clk_sys) disable iff (reset)
		$past(policy) == board_ctrl_pkg::POLICY_STAY_OFF
		|-> !power_up_req)
		else $error("stay-off policy powered up");
	a_state_stored: assert property (@(posedge clk_sys)
		disable iff (reset)
		$changed(sys_on) |=> last_state_on == $past(sys_on))
		else $error("power state not stored");
	a_kick_clears: assert property (@(posedge clk_sys) disable iff (reset)
		wdog_kick |=> wdog_stage == 2'h0 && !wdog_reset_req)
		else $error("kick did not restart watchdog");
	a_pwm_zero_off: assert property (@(posedge clk_sys) disable iff (reset)
		fan_duty == 8'h0 |=> !fan_speed_pulse_out)
		else $error("fan pwm high at zero duty");

endmodule : board_ctrl

// file: sim/fan_rail_model.sv
// Partner model: system fan tach source and standby rail.
// Assumes pulse_cyc is at least 2 clocks; rail follows rail_on.
`timescale 1ns/1ps
module fan_rail_model (
	input  wire logic       clk_sys,
	input  wire logic [7:0] pulse_cyc,
	input  wire logic       rail_on,
	output logic            tach,
	output logic            standby_good
);
	logic [7:0] cnt = 8'h00;
	// One pulse every pulse_cyc clocks; a revolution is two pulses
	always @(posedge clk_sys) begin
		cnt <= (cnt + 8'h01 >= pulse_cyc) ? 8'h00 : cnt + 8'h01;
	end
	assign tach = (cnt < pulse_cyc / 8'h02);
	assign standby_good = rail_on;
endmodule : fan_rail_model

// file: sim/testbench.sv
// Self-checking bench: power loss policies, fan PWM and tach, watchdog.
// Assumes the short window, gate and stage parameters set below.
`timescale 1ns/1ps
module testbench;
	logic                            clk_sys = 1'b0;
	logic                            reset;
	logic                            standby_good;
	logic                            standby_supported;
	board_ctrl_pkg::policy_type      policy;
	logic                            sys_on;
	logic                            tach;
	logic [7:0]                      fan_duty;
	logic                            wdog_enable;
	logic                            wdog_kick;
	board_ctrl_pkg::wdog_action_type act [3];
	logic                            power_up_req;
	logic                            proper_off;
	logic                            ac_loss;
	logic                            last_state_on;
	logic                            fan_speed_pulse_out;
	logic [15:0]                     fan_rpm;
	logic [1:0]                      wdog_stage;
	logic                            wdog_event;
	logic                            wdog_reset_req;
	logic                            wdog_power_off_req;
	logic [7:0]                      pulse_cyc;
	logic                            rail_on;
	int errors = 0;
	int total_checks = 0;
	int seed = 32'hd3f8;
	int cyc = 0;
	int pu = 0;
	int ev = 0;
	int rs = 0;
	int po = 0;
	int hi;
	int t_pol [5] = '{2, 2, 0, 1, 0};
	int t_sup [5] = '{1, 1, 1, 1, 0};
	int t_drop [5] = '{20, 0, 20, 20, 20};
	int e_ac [5] = '{1, 0, 0, 0, 0};
	int e_po [5] = '{0, 1, 0, 0, 0};
	int e_pu [5] = '{1, 0, 1, 0, 0};
	int t_per [3] = '{10, 20, 50};

	always #20 clk_sys = ~clk_sys;

	fan_rail_model partner (
		.clk_sys      (clk_sys),
		.pulse_cyc    (pulse_cyc),
		.rail_on      (rail_on),
		.tach         (tach),
		.standby_good (standby_good)
	);

	board_ctrl #(
		.STANDBY_WIN_CYC (200),
		.GATE_CYC        (100),
		.WDOG_STAGE_CYC  (50)
	) uut (
		.clk_sys               (clk_sys),
		.reset                 (reset),
		.standby_good          (standby_good),
		.standby_supported     (standby_supported),
		.policy                (policy),
		.sys_on                (sys_on),
		.fan_rotation_pulse_in (tach),
		.fan_duty              (fan_duty),
		.wdog_enable           (wdog_enable),
		.wdog_kick             (wdog_kick),
		.wdog_stage_action     (act),
		.power_up_req          (power_up_req),
		.proper_off            (proper_off),
		.ac_loss               (ac_loss),
		.last_state_on         (last_state_on),
		.fan_speed_pulse_out   (fan_speed_pulse_out),
		.fan_rpm               (fan_rpm),
		.wdog_stage            (wdog_stage),
		.wdog_event            (wdog_event),
		.wdog_reset_req        (wdog_reset_req),
		.wdog_power_off_req    (wdog_power_off_req)
	);

	// Pulse outputs stand one cycle, so they are counted every edge
	always @(posedge clk_sys) begin
		cyc++;
		pu += (power_up_req === 1'b1);
		ev += (wdog_event === 1'b1);
		rs += (wdog_reset_req === 1'b1);
		po += (wdog_power_off_req === 1'b1);
		if (cyc >= 10000) begin
			errors++;
			end_sim();
		end
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		#1;
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : tick

	task automatic end_sim();
		$display("checks=%0d errors=%0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : end_sim

	initial begin
		reset = 1'b1;
		standby_supported = 1'b1;
		policy = board_ctrl_pkg::POLICY_PREVIOUS;
		sys_on = 1'b1;
		fan_duty = 8'h00;
		wdog_enable = 1'b0;
		wdog_kick = 1'b0;
		act = '{board_ctrl_pkg::WACT_EVENT, board_ctrl_pkg::WACT_RESET,
			board_ctrl_pkg::WACT_POWER_OFF};
		pulse_cyc = 8'h0a;
		rail_on = 1'b1;
		tick(8);
		reset <= 1'b0;
		check(fan_rpm, 16'h0000);
		for (int i = 0; i < 3; i++) begin
			tick(1);
			pulse_cyc <= 8'(t_per[i]);
			fan_duty <= 8'($random(seed));
			tick(300);
			check(fan_rpm, 16'((100 / t_per[i]
				/ board_ctrl_pkg::PULSES_PER_REV)
				* board_ctrl_pkg::RPM_SCALE));
			hi = 0;
			repeat (256) begin
				@(posedge clk_sys);
				hi += (fan_speed_pulse_out === 1'b1);
			end
			check(16'(hi), {8'h00, fan_duty});
		end
		// Loss or clean stay while off; the window only matters under previous-state
		for (int i = 0; i < 5; i++) begin
			tick(1);
			policy <= board_ctrl_pkg::policy_type'(t_pol[i]);
			standby_supported <= 1'(t_sup[i]);
			sys_on <= 1'b1;
			tick(5);
			pu = 0;
			sys_on <= 1'b0;
			if (t_drop[i] > 0) begin
				tick(t_drop[i]);
				rail_on <= 1'b0;
				tick(10);
			end else
				tick(230);
			check(ac_loss, 16'(e_ac[i]));
			check(proper_off, 16'(e_po[i]));
			// A loss in the window reads as on; a clean off stays off
			check(last_state_on, 16'(e_ac[i]));
			tick(1);
			rail_on <= 1'b1;
			tick(10);
			// Previous-state restores on after a loss inside the window
			check(16'(pu), 16'(e_pu[i]));
		end
		tick(1);
		ev = 0;
		rs = 0;
		po = 0;
		wdog_enable <= 1'b1;
		tick(55);
		check({wdog_stage, 8'(ev)}, {2'h1, 8'h01});
		tick(50);
		check({wdog_stage, 8'(rs)}, {2'h2, 8'h01});
		tick(50);
		check({wdog_stage, 8'(po)}, {2'h2, 8'h01});
		tick(1);
		wdog_kick <= 1'b1;
		tick(1);
		wdog_kick <= 1'b0;
		tick(1);
		check(wdog_stage, 16'h0000);
		end_sim();
	end
endmodule : testbench
